// ==== core/time_stamp_capture_buffer.v ====
// Time stamp capture unit with two-bank record buffer and AXI4-Lite registers
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "stamp_capture_map.vh"
module time_stamp_capture_buffer (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Event sources, one-cycle pulses
	input  wire        ext_event_pin_1,
	input  wire        ext_event_pin_2,
	input  wire        reset_out_event,
	input  wire        voltage_drop_event,
	input  wire        osc_stop_event,
	// Levels captured into the status byte
	input  wire        ext_input1_level,
	input  wire        ext_input2_level,
	input  wire        reset_out_level,
	input  wire        voltage_drop_level,
	input  wire        osc_stop_level,
	// Counters of the clock
	input  wire [9:0]  subsecond_count,
	input  wire [47:0] calendar_bcd,
	input  wire [32:0] binary_seconds,
	// Interrupt request to the pin logic
	output reg         stamp_irq
);
	// ----------------------------------------
	// Register file
	// ----------------------------------------
	reg  [4:0]  event_interrupt_enable_reg;
	reg  [4:0]  stamp_buffer_config;
	reg  [7:0]  command_config_reg;
	reg  [7:0]  command_trigger_reg;
	reg         stamp_irq_global_en;
	reg  [3:0]  ext_input_enable_reg;
	reg  [2:0]  internal_capture_enable_reg;
	reg  [2:0]  stamp_buffer_status;
	reg  [7:0]  irq_pending_reg;
	reg  [79:0] bank_mem [0:1];
	reg         cmd_pending_reg;

	wire ext_input1_irq_en        = event_interrupt_enable_reg[`EVIE_IN1];
	wire ext_input2_irq_en        = event_interrupt_enable_reg[`EVIE_IN2];
	wire reset_out_event_irq_en   = event_interrupt_enable_reg[`EVIE_RSTO];
	wire voltage_drop_event_irq_en = event_interrupt_enable_reg[`EVIE_VDROP];
	wire osc_stop_event_irq_en    = event_interrupt_enable_reg[`EVIE_OSC];
	wire buffer_full_irq_en       = stamp_buffer_config[`CFG_FULL_IE];
	wire buffer_not_empty_irq_en  = stamp_buffer_config[`CFG_NEMPTY_IE];
	wire buffer_overwrite_irq_en  = stamp_buffer_config[`CFG_OVW_IE];
	wire binary_format_select     = stamp_buffer_config[`CFG_BINARY_FORMAT_SELECT];
	wire overwrite_allow          = stamp_buffer_config[`CFG_OVW_ALLOW];
	wire flag_reset_on_command    = command_config_reg[`CMD_FLAG_RESET];
	wire counter_clear_on_command = command_config_reg[`CMD_COUNTER_CLR];
	wire capture_on_command       = command_config_reg[`CMD_CAPTURE];
	wire ext_input1_capture_en    = ext_input_enable_reg[`EXT_IN1_CAP];
	wire ext_input2_capture_en    = ext_input_enable_reg[`EXT_IN2_CAP];
	wire ext_input1_active        = ext_input_enable_reg[`EXT_IN1_ACT];
	wire ext_input2_active        = ext_input_enable_reg[`EXT_IN2_ACT];
	wire buffer_empty_flag        = stamp_buffer_status[`ST_EMPTY];
	wire buffer_full_flag         = stamp_buffer_status[`ST_FULL];
	wire buffer_overwrite_flag    = stamp_buffer_status[`ST_OVW];

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;

	function [7:0] merge_byte;
		input [7:0] old_val;
		input [31:0] data;
		input [3:0] strb;
		begin
			merge_byte = strb[0] ? data[7:0] : old_val;
		end
	endfunction

	function sel;
		input [7:0] addr;
		input [7:0] target;
		begin
			sel = (addr[7:2] == target[7:2]);
		end
	endfunction

	wire wr_evie = wr_go && sel(s_axi_awaddr, `ADDR_EVENT_IRQ_EN);
	wire wr_bcfg = wr_go && sel(s_axi_awaddr, `ADDR_BUFFER_CONFIG);
	wire wr_ccfg = wr_go && sel(s_axi_awaddr, `ADDR_COMMAND_CONFIG);
	wire wr_ctrg = wr_go && sel(s_axi_awaddr, `ADDR_COMMAND_TRIGGER) && s_axi_wstrb[0];
	wire wr_gate = wr_go && sel(s_axi_awaddr, `ADDR_STAMP_GATE);
	wire wr_exen = wr_go && sel(s_axi_awaddr, `ADDR_EXT_INPUT_EN);
	wire wr_icap = wr_go && sel(s_axi_awaddr, `ADDR_INT_CAPTURE_EN);
	wire wr_irqs = wr_go && sel(s_axi_awaddr, `ADDR_IRQ_STATUS) && s_axi_wstrb[0];
	wire wr_hit  = wr_evie | wr_bcfg | wr_ccfg | wr_gate | wr_exen | wr_icap
		| (wr_go && sel(s_axi_awaddr, `ADDR_COMMAND_TRIGGER))
		| (wr_go && sel(s_axi_awaddr, `ADDR_IRQ_STATUS));

	// ----------------------------------------
	// Event qualification
	// ----------------------------------------
	wire in1_evt = ext_event_pin_1 && ext_input1_active;
	wire in2_evt = ext_event_pin_2 && ext_input2_active;
	wire cmd_fire = cmd_pending_reg;
	wire cmd_cap  = cmd_fire && capture_on_command;
	wire cap_in1  = in1_evt && ext_input1_capture_en;
	wire cap_in2  = in2_evt && ext_input2_capture_en;
	wire cap_rsto = reset_out_event && internal_capture_enable_reg[`CAP_RSTO];
	wire cap_vdr  = voltage_drop_event && internal_capture_enable_reg[`CAP_VDROP];
	wire cap_osc  = osc_stop_event && internal_capture_enable_reg[`CAP_OSC];
	wire capture  = cap_in1 | cap_in2 | cap_rsto | cap_vdr | cap_osc | cmd_cap;
	wire flag_clr = cmd_fire && flag_reset_on_command;

	// Snapshot taken from one cycle of the counters
	wire [39:0] date_field = binary_format_select ? {7'h00, binary_seconds}
		: calendar_bcd[39:0];
	wire [7:0] year_field = binary_format_select ? 8'h00 : calendar_bcd[47:40];
	wire [7:0] state_byte = {1'b0, ext_input2_level, ext_input1_level, 1'b0,
		reset_out_level, voltage_drop_level, 1'b0, osc_stop_level};
	wire will_ovw = buffer_full_flag && !flag_clr;
	wire [7:0] cause_byte = {will_ovw, cap_in2, cap_in1, cmd_cap,
		cap_rsto, cap_vdr, 1'b0, cap_osc};
	wire [79:0] record = {cause_byte, state_byte, year_field, date_field,
		subsecond_count[9:2], subsecond_count[1:0], 6'h00};

	// ----------------------------------------
	// Buffer state and command handling
	// ----------------------------------------
	reg [2:0] status_next;
	reg       write_b6;
	reg       write_b7;
	always @* begin
		status_next = stamp_buffer_status;
		write_b6 = 1'b0;
		write_b7 = 1'b0;
		if (flag_clr)
			status_next = `STATUS_RESET;
		if (capture) begin
			if (flag_clr || buffer_empty_flag) begin
				// Clear and capture in one cycle: the capture lands in an empty buffer
				write_b6 = 1'b1;
				status_next = 3'h0;
			end else if (!buffer_full_flag) begin
				write_b7 = 1'b1;
				status_next = 3'h2;
			end else begin
				write_b7 = overwrite_allow;
				status_next = 3'h6;
			end
		end
	end

	always @(posedge aclk) begin
		if (write_b6)
			bank_mem[0] <= record;
		if (write_b7)
			bank_mem[1] <= record;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			event_interrupt_enable_reg  <= 5'h00;
			stamp_buffer_config         <= 5'h00;
			command_config_reg          <= 8'h00;
			command_trigger_reg         <= `TRIGGER_IDLE;
			stamp_irq_global_en         <= 1'b0;
			ext_input_enable_reg        <= 4'h0;
			internal_capture_enable_reg <= 3'h0;
			stamp_buffer_status         <= `STATUS_RESET;
			cmd_pending_reg             <= 1'b0;
		end else begin
			stamp_buffer_status <= status_next;
			if (wr_evie)
				event_interrupt_enable_reg <= s_axi_wstrb[0] ? s_axi_wdata[4:0]
					: event_interrupt_enable_reg;
			if (wr_bcfg)
				stamp_buffer_config <= s_axi_wstrb[0] ? s_axi_wdata[4:0] : stamp_buffer_config;
			if (wr_ccfg)
				command_config_reg <= merge_byte(command_config_reg, s_axi_wdata, s_axi_wstrb);
			if (wr_gate)
				stamp_irq_global_en <= s_axi_wstrb[0] ? s_axi_wdata[0] : stamp_irq_global_en;
			if (wr_exen)
				ext_input_enable_reg <= s_axi_wstrb[0] ? s_axi_wdata[3:0] : ext_input_enable_reg;
			if (wr_icap)
				internal_capture_enable_reg <= s_axi_wstrb[0] ? s_axi_wdata[2:0]
					: internal_capture_enable_reg;
			// Command runs the cycle after the write; register then reads zero
			cmd_pending_reg <= wr_ctrg;
			if (wr_ctrg)
				command_trigger_reg <= s_axi_wdata[7:0];
			else if (cmd_fire)
				command_trigger_reg <= `TRIGGER_IDLE;
		end
	end

	// ----------------------------------------
	// Event counters
	// ----------------------------------------
	wire [5:0] count1;
	wire [5:0] count2;
	wire       cnt_clr = cmd_fire && counter_clear_on_command;
	stamp_event_counter u_count1 (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.event_pulse (in1_evt),
		.clear       (cnt_clr),
		.count       (count1)
	);
	stamp_event_counter u_count2 (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.event_pulse (in2_evt),
		.clear       (cnt_clr),
		.count       (count2)
	);

	// ----------------------------------------
	// Interrupt flags, write one to clear, set wins
	// ----------------------------------------
	wire [7:0] irq_set = {
		capture && !flag_clr && buffer_full_flag,                       // overwrite
		capture && !(flag_clr || buffer_empty_flag) && !buffer_full_flag, // full
		capture && (flag_clr || buffer_empty_flag),                      // not empty
		osc_stop_event, voltage_drop_event, reset_out_event, in2_evt, in1_evt};
	wire [7:0] irq_en = {buffer_overwrite_irq_en, buffer_full_irq_en,
		buffer_not_empty_irq_en, osc_stop_event_irq_en, voltage_drop_event_irq_en,
		reset_out_event_irq_en, ext_input2_irq_en, ext_input1_irq_en};
	wire [7:0] irq_clr = wr_irqs ? s_axi_wdata[7:0] : 8'h00;

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_pending_reg <= 8'h00;
			stamp_irq       <= 1'b0;
		end else begin
			irq_pending_reg <= (irq_pending_reg & ~irq_clr) | irq_set;
			stamp_irq <= stamp_irq_global_en && |(irq_pending_reg & irq_en);
		end
	end

	// ----------------------------------------
	// Write response
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	wire rd_go = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = rd_go;

	wire [7:0]  bank6_base = `ADDR_BANK6_BASE;
	wire [7:0]  bank7_base = `ADDR_BANK7_BASE;
	wire [7:0]  bank_end   = `ADDR_BANK_LAST_WORD;
	wire        bank_hit = (s_axi_araddr[7:6] == bank6_base[7:6]
		|| s_axi_araddr[7:6] == bank7_base[7:6]) && (s_axi_araddr[5:0] < bank_end[5:0]);
	wire [79:0] bank_rec = s_axi_araddr[7] ? bank_mem[1] : bank_mem[0];
	wire [95:0] bank_pad = {16'h0000, bank_rec};

	reg  [31:0] rd_mux;
	reg         rd_ok;
	always @* begin
		rd_mux = 32'h00000000;
		rd_ok = 1'b1;
		case (s_axi_araddr & 8'hFC)
		`ADDR_EVENT_IRQ_EN:    rd_mux = {27'h0, event_interrupt_enable_reg};
		`ADDR_BUFFER_CONFIG:   rd_mux = {27'h0, stamp_buffer_config};
		`ADDR_COMMAND_CONFIG:  rd_mux = {24'h0, command_config_reg};
		`ADDR_COMMAND_TRIGGER: rd_mux = {24'h0, command_trigger_reg};
		`ADDR_STAMP_GATE:      rd_mux = {31'h0, stamp_irq_global_en};
		`ADDR_EXT_INPUT_EN:    rd_mux = {28'h0, ext_input_enable_reg};
		`ADDR_INT_CAPTURE_EN:  rd_mux = {29'h0, internal_capture_enable_reg};
		`ADDR_BUFFER_STATUS:   rd_mux = {29'h0, buffer_overwrite_flag, buffer_full_flag,
			buffer_empty_flag};
		`ADDR_EVENT_COUNT1:    rd_mux = {26'h0, count1};
		`ADDR_EVENT_COUNT2:    rd_mux = {26'h0, count2};
		`ADDR_IRQ_STATUS:      rd_mux = {24'h0, irq_pending_reg};
		default: begin
			if (bank_hit) begin
				case (s_axi_araddr[3:2])
				2'h0:    rd_mux = bank_pad[31:0];
				2'h1:    rd_mux = bank_pad[63:32];
				default: rd_mux = bank_pad[95:64];
				endcase
			end else
				rd_ok = 1'b0;
		end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule
`default_nettype wire

// ==== core/stamp_capture_map.vh ====
// Register map, field positions and constants of the time stamp capture unit
`ifndef STAMP_CAPTURE_MAP_VH
`define STAMP_CAPTURE_MAP_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_EVENT_IRQ_EN      8'h00
`define ADDR_BUFFER_CONFIG     8'h04
`define ADDR_COMMAND_CONFIG    8'h08
`define ADDR_COMMAND_TRIGGER   8'h0C
`define ADDR_STAMP_GATE        8'h10
`define ADDR_EXT_INPUT_EN      8'h14
`define ADDR_INT_CAPTURE_EN    8'h18
`define ADDR_BUFFER_STATUS     8'h1C
`define ADDR_EVENT_COUNT1      8'h20
`define ADDR_EVENT_COUNT2      8'h24
`define ADDR_IRQ_STATUS        8'h28
`define ADDR_BANK6_BASE        8'h40
`define ADDR_BANK7_BASE        8'h80
`define ADDR_BANK_LAST_WORD    8'h0C

// ----------------------------------------
// Fields
// ----------------------------------------
`define EVIE_IN1               0
`define EVIE_IN2               1
`define EVIE_RSTO              2
`define EVIE_VDROP             3
`define EVIE_OSC               4
`define CFG_FULL_IE            0
`define CFG_NEMPTY_IE          1
`define CFG_OVW_IE             2
`define CFG_BINARY_FORMAT_SELECT             3
`define CFG_OVW_ALLOW          4
`define CMD_CAPTURE            0
`define CMD_COUNTER_CLR        4
`define CMD_FLAG_RESET         7
`define EXT_IN1_CAP            0
`define EXT_IN2_CAP            1
`define EXT_IN1_ACT            2
`define EXT_IN2_ACT            3
`define CAP_RSTO               0
`define CAP_VDROP              1
`define CAP_OSC                2
`define ST_EMPTY               0
`define ST_FULL                1
`define ST_OVW                 2

// ----------------------------------------
// Reset values and widths
// ----------------------------------------
`define STATUS_RESET           3'h1
`define COUNT_MAX              6'h3F
`define COUNT_ZERO             6'h00
`define TRIGGER_IDLE           8'h00
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2
`define RECORD_BITS            80

`endif

// ==== core/stamp_event_counter.v ====
// Six-bit event counter for one external input
`timescale 1ns/1ns
`default_nettype none
`include "stamp_capture_map.vh"
module stamp_event_counter (
	// Clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	// Control
	input  wire       event_pulse,
	input  wire       clear,
	// Count
	output reg  [5:0] count
);
	always @(posedge aclk) begin
		if (!aresetn)
			count <= `COUNT_ZERO;
		else if (clear)
			count <= `COUNT_ZERO;
		else if (event_pulse)
			count <= (count == `COUNT_MAX) ? `COUNT_ZERO : count + 6'h01;
	end
endmodule
`default_nettype wire

// ==== bench/stamp_capture_checker_sva.sv ====
// Bus and behaviour checker for the time stamp capture unit
`timescale 1ns/1ns
`default_nettype none
module stamp_capture_checker (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Interrupt
	input wire logic        stamp_irq
);
	logic trig_wr;
	logic trig_wr_reg;
	// Trigger reads back nonzero for one edge after it is written
	assign trig_wr = s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h0C;
	always_ff @(posedge aclk)
		trig_wr_reg <= aresetn && trig_wr;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	write_accept_a: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
		&& s_axi_wready == s_axi_awready) else $error("write accept wrong");
	write_resp_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write response late");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'hFC
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read wrong");
	bad_write_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'hFC
		|=> s_axi_bresp == 2'h2) else $error("unmapped write wrong");
	trigger_idle_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0C
		&& !trig_wr && !trig_wr_reg |=> s_axi_rdata[7:0] == 8'h00) else $error("trigger not idle");
	quiet_reset_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !stamp_irq)
		else $error("outputs busy after reset");
endmodule
bind time_stamp_capture_buffer stamp_capture_checker i_checker (.*);
`default_nettype wire

// ==== bench/axi_host_model.sv ====
// Host model: register bus master for writes, reads and commands
`timescale 1ns/1ns
`default_nettype none
module axi_host_model #(
	parameter int CMD_GAP = 16
) (
	// Clock
	input  wire logic        aclk,
	// Write channels
	output logic      [7:0]  s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic      [31:0] s_axi_wdata,
	output logic      [3:0]  s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	// Read channels
	output logic      [7:0]  s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_wstrb = 4'hF;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (!s_axi_bvalid) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Gap shortened from the real spacing to keep runs short
	task automatic cmd(input logic [7:0] cfg);
		logic [1:0] r;
		wr(8'h08, {24'h0, cfg}, r);
		wr(8'h0C, 32'h0000_00A5, r);
		repeat (CMD_GAP) @(posedge aclk);
	endtask
endmodule
`default_nettype wire

// ==== bench/time_stamp_capture_buffer_tb.sv ====
// Testbench of the time stamp capture unit
`timescale 1ns/1ns
`default_nettype none
module time_stamp_capture_buffer_tb;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [4:0]  ev = 5'h00;
	logic [9:0]  subsecond_count = 10'h2C7;
	logic [47:0] calendar_bcd = 48'h0;
	logic [32:0] binary_seconds = 33'h0;
	logic        stamp_irq;
	int          num_errors = 0;
	int          checks = 0;
	wire ext_event_pin_1 = ev[0];
	wire ext_event_pin_2 = ev[1];
	wire reset_out_event = ev[2];
	wire voltage_drop_event = ev[3];
	wire osc_stop_event = ev[4];
	wire ext_input1_level = 1'b1;
	wire ext_input2_level = 1'b0;
	wire reset_out_level = 1'b1;
	wire voltage_drop_level = 1'b0;
	wire osc_stop_level = 1'b1;
	axi_host_model #(.CMD_GAP(16)) i_host (.*);
	time_stamp_capture_buffer i_dut (.*);
	always #25 aclk = ~aclk;
	// ----------------
	// Helpers
	// ----------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m,
			input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		i_host.rd(a, d, r);
		chk(what, exp, d & m);
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		i_host.wr(a, d, r);
	endtask
	task automatic pulse(input int i);
		@(posedge aclk);
		ev[i] <= 1'b1;
		@(posedge aclk);
		ev[i] <= 1'b0;
		@(posedge aclk);
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		rchk("status", 8'h1C, 32'h7, 32'h1);
		rchk("trigger", 8'h0C, 32'hFF, 32'h0);
		i_host.rd(8'hFC, d, r);
		chk("unmapped rresp", 32'h2, {30'h0, r});
		i_host.wr(8'hFC, 32'h1, r);
		chk("unmapped bresp", 32'h2, {30'h0, r});
		$display("test reset done");
	endtask
	task automatic t_inhibit();
		w(8'h10, 32'h0);
		w(8'h00, 32'h1F);
		w(8'h04, 32'h07);
		i_host.cmd(8'h90);
		w(8'h10, 32'h1);
		w(8'h14, 32'h3);
		w(8'h14, 32'hF);
		w(8'h18, 32'h0);
		calendar_bcd[7:0] <= 8'h12;
		pulse(0);
		rchk("status first", 8'h1C, 32'h7, 32'h0);
		rchk("bank6", 8'h40, 32'hFFFF_FFC0, 32'h0012_B1C0);
		calendar_bcd[7:0] <= 8'h34;
		pulse(0);
		rchk("status second", 8'h1C, 32'h7, 32'h2);
		rchk("bank7", 8'h80, 32'h00FF_0000, 32'h0034_0000);
		calendar_bcd[7:0] <= 8'h56;
		pulse(0);
		rchk("status third", 8'h1C, 32'h7, 32'h6);
		rchk("bank7 kept", 8'h80, 32'h00FF_0000, 32'h0034_0000);
		rchk("count1", 8'h20, 32'h3F, 32'h3);
		$display("test inhibit done");
	endtask
	task automatic t_overwrite();
		i_host.cmd(8'h90);
		rchk("status clear", 8'h1C, 32'h7, 32'h1);
		rchk("bank6 kept", 8'h40, 32'h00FF_0000, 32'h0012_0000);
		rchk("trigger idle", 8'h0C, 32'hFF, 32'h0);
		rchk("count cleared", 8'h20, 32'h3F, 32'h0);
		w(8'h04, 32'h1F);
		w(8'h28, 32'hFF);
		for (int k = 0; k < 3; k++) begin
			binary_seconds[7:0] <= 8'hA0 + k[7:0];
			pulse(1);
		end
		rchk("status ovw", 8'h1C, 32'h7, 32'h6);
		rchk("irq buffer flags", 8'h28, 32'hE0, 32'hE0);
		rchk("bank7 cause", 8'h88, 32'hFFFF_FFFF, 32'h0000_C029);
		rchk("bank6 binary", 8'h40, 32'h00FF_0000, 32'h00A0_0000);
		rchk("bank7 latest", 8'h80, 32'h00FF_0000, 32'h00A2_0000);
		rchk("count2", 8'h24, 32'h3F, 32'h3);
		$display("test overwrite done");
	endtask
	task automatic t_wrap();
		i_host.cmd(8'h90);
		repeat (63) pulse(0);
		rchk("count top", 8'h20, 32'h3F, 32'h3F);
		pulse(0);
		rchk("count wrap", 8'h20, 32'h3F, 32'h0);
		w(8'h14, 32'hA);
		pulse(0);
		rchk("count inactive", 8'h20, 32'h3F, 32'h0);
		i_host.cmd(8'h91);
		rchk("status command", 8'h1C, 32'h7, 32'h0);
		rchk("bank6 command", 8'h48, 32'hFFFF_FFFF, 32'h0000_1029);
		$display("test wrap done");
	endtask
	task automatic t_irq();
		w(8'h04, 32'h10);
		w(8'h00, 32'h04);
		w(8'h18, 32'h0);
		w(8'h28, 32'hFF);
		chk("irq idle", 32'h0, {31'h0, stamp_irq});
		pulse(3);
		repeat (2) @(posedge aclk);
		chk("irq masked", 32'h0, {31'h0, stamp_irq});
		pulse(2);
		repeat (2) @(posedge aclk);
		chk("irq event", 32'h1, {31'h0, stamp_irq});
		w(8'h28, 32'hFF);
		w(8'h10, 32'h0);
		pulse(2);
		repeat (2) @(posedge aclk);
		chk("irq gated", 32'h0, {31'h0, stamp_irq});
		$display("test irq done");
	endtask
	task automatic t_internal();
		w(8'h00, 32'h0);
		w(8'h04, 32'h02);
		w(8'h10, 32'h1);
		for (int i = 0; i < 3; i++) begin
			i_host.cmd(8'h90);
			w(8'h18, 32'h1 << i);
			w(8'h28, 32'hFF);
			pulse(2 + i);
			rchk("status internal", 8'h1C, 32'h7, 32'h0);
			chk("irq not empty", 32'h1, {31'h0, stamp_irq});
		end
		$display("test internal done");
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_inhibit();
		t_overwrite();
		t_wrap();
		t_irq();
		t_internal();
		end_of_test();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (30000) @(posedge aclk);
		num_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
